//--- design/cel_curve_eval.sv
// Behaviour
// - six limit outputs, each on channel X or Y with own limit, asserted when exceeded
// - each limit output has selectable active-high or active-low level
// - X absolute reference compares limit against the raw X measurement
// - trigger-relative X measures from X at trigger; only with Y-trigger mode
// - outputs a and b fixed to controller pins; c..f routed by configuration
// - with a nonzero band, boundary chatter within the band gives no fail
// - without a band, entering and leaving a window more than once fails
// - one global X and one global Y band width for all elements
// - band enabled when any width above 0; element area grows by the band
// - envelope generation refused with not-continuous error unless single-valued
// - envelope has entry side, start, end, lower and upper offsets
// - envelope check applies only to the chosen forward or return segment
// - pass when curve stays in envelope band, fail on any excursion
// - sensor test compares live value of active channels with reference and tolerance
// - sensor test started by request input or function key
// - sensor test result output is 1 within tolerance, 0 outside
`timescale 1ns/10ps
`default_nettype none
module cel_curve_eval
  import cel_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire cel_sample_t sample,
  input wire cel_bus_t bus,
  input wire logic sensor_check_request,
  input wire logic functionKey,
  input wire logic genStrobe,
  input wire logic genMonotonic,
  output logic [31:0] rdata,
  output logic limit_switch_out_a,
  output logic limit_switch_out_b,
  output logic [CEL_NOUT-1:0] plcOut,
  output logic sensor_check_pass,
  output logic sensor_check_done,
  output logic fail_verdict,
  output logic envNotContinuous
);

  logic [2:0] swCfg_q [CEL_NSW];
  logic signed [CEL_DW-1:0] swLim_q [CEL_NSW];
  logic [15:0] route_q;
  logic modeYtrig_q;
  logic [CEL_DW-1:0] tolX_q, tolY_q, stTol_q;
  logic [3:0] envCfg_q;
  logic signed [CEL_DW-1:0] envStart_q, envEnd_q, envDlo_q, envDhi_q, winLo_q, winHi_q;
  logic signed [CEL_DW-1:0] stRefX_q, stRefY_q;
  logic [1:0] stEn_q;
  logic envArmed_q;

  function automatic logic signed [CEL_DW-1:0] absDiff(input logic signed [CEL_DW-1:0] a,
                                                      input logic signed [CEL_DW-1:0] b);
    logic signed [CEL_DW-1:0] d;
    d = a - b;
    return d[CEL_DW-1] ? -d : d;
  endfunction : absDiff

  // register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < CEL_NSW; i++) begin
        swCfg_q[i] <= 3'h0;
        swLim_q[i] <= 16'sh7fff;
      end
      route_q <= CEL_ROUTE_RST;
      modeYtrig_q <= 1'b0;
      tolX_q <= 16'h0;
      tolY_q <= 16'h0;
      envCfg_q <= 4'h0;
      envStart_q <= 16'sh0;
      envEnd_q <= 16'sh0;
      envDlo_q <= 16'sh0;
      envDhi_q <= 16'sh0;
      winLo_q <= 16'sh0;
      winHi_q <= 16'sh0;
      stRefX_q <= 16'sh0;
      stRefY_q <= 16'sh0;
      stTol_q <= 16'h0;
      stEn_q <= 2'h0;
    end else if (bus.wr) begin
      if (bus.addr < CEL_A_SWCFG0 + 8'(CEL_NSW)) begin
        swCfg_q[bus.addr[2:0]] <= bus.wdata[2:0];
        // trigger reference is refused unless the mode uses the Y-trigger crossing
        if (!modeYtrig_q) swCfg_q[bus.addr[2:0]][CEL_SW_REL] <= 1'b0;
      end else if (bus.addr >= CEL_A_SWLIM0 && bus.addr < CEL_A_SWLIM0 + 8'(CEL_NSW)) begin
        swLim_q[3'(bus.addr - CEL_A_SWLIM0)] <= bus.wdata[CEL_DW-1:0];
      end else begin
        unique case (bus.addr)
          CEL_A_SWROUTE: route_q <= bus.wdata[15:0];
          CEL_A_MODE: modeYtrig_q <= bus.wdata[CEL_MODE_YTRIG];
          CEL_A_TOLX: tolX_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_TOLY: tolY_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_ENVCFG: envCfg_q <= bus.wdata[3:0];
          CEL_A_ENVSTART: envStart_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_ENVEND: envEnd_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_ENVDLO: envDlo_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_ENVDHI: envDhi_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_WINLO: winLo_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_WINHI: winHi_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_STREFX: stRefX_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_STREFY: stRefY_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_STTOL: stTol_q <= bus.wdata[CEL_DW-1:0];
          CEL_A_CTRL: stEn_q <= bus.wdata[1:0];
          default: ;
        endcase
      end
    end
  end

  // envelope generation: refused unless the reference segment is single-valued
  always_ff @(posedge clk) begin
    if (reset) begin
      envArmed_q <= 1'b0;
      envNotContinuous <= 1'b0;
    end else if (genStrobe) begin
      envArmed_q <= genMonotonic;
      envNotContinuous <= !genMonotonic;
    end
  end

  // limit switches
  logic signed [CEL_DW-1:0] xTrig_q;
  logic [CEL_NSW-1:0] swAct_q;
  logic [CEL_NSW-1:0] swLvl;

  always_ff @(posedge clk) begin
    if (reset) xTrig_q <= 16'sh0;
    else if (sample.valid && sample.trig) xTrig_q <= sample.x;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      swAct_q <= '0;
    end else if (sample.valid) begin
      for (int i = 0; i < CEL_NSW; i++) begin
        if (swCfg_q[i][CEL_SW_CHAN]) swAct_q[i] <= sample.y > swLim_q[i];
        else if (swCfg_q[i][CEL_SW_REL])
          swAct_q[i] <= (sample.x - xTrig_q) > swLim_q[i];
        else swAct_q[i] <= sample.x > swLim_q[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < CEL_NSW; i++) swLvl[i] = swAct_q[i] ^ swCfg_q[i][CEL_SW_POL];
  end

  // outputs follow the sample two cycles later, well inside a sample period
  always_ff @(posedge clk) begin
    if (reset) begin
      limit_switch_out_a <= 1'b0;
      limit_switch_out_b <= 1'b0;
      plcOut <= '0;
    end else begin
      limit_switch_out_a <= swLvl[0];
      limit_switch_out_b <= swLvl[1];
      for (int p = 0; p < CEL_NOUT; p++) begin
        plcOut[p] <= 1'b0;
        for (int k = 0; k < 4; k++)
          if (route_q[4*k +: 4] == 4'(p)) plcOut[p] <= swLvl[k+2];
      end
    end
  end

  // window in X with global hysteresis band
  logic bandOn;
  logic inWin, inBand;
  logic winInside_q, winEntered_q, winFail_q, envFail_q;
  assign bandOn = (tolX_q != 16'h0) || (tolY_q != 16'h0);
  assign inWin = sample.x >= winLo_q && sample.x <= winHi_q;
  assign inBand = sample.x >= winLo_q - $signed(tolX_q) && sample.x <= winHi_q + $signed(tolX_q);

  always_ff @(posedge clk) begin
    if (reset || (sample.valid && sample.frameStart)) begin
      winInside_q <= 1'b0;
      winEntered_q <= 1'b0;
      winFail_q <= 1'b0;
    end else if (sample.valid) begin
      if (bandOn) begin
        // once inside the window, chatter in the enlarged band is not a re-entry
        if (inWin) winEntered_q <= 1'b1;
        if (!inBand && winInside_q && winEntered_q) winInside_q <= 1'b0;
        else if (inWin) winInside_q <= 1'b1;
        if (inWin && !winInside_q && winEntered_q) winFail_q <= 1'b1;
      end else begin
        winInside_q <= inWin;
        if (inWin && !winInside_q) winEntered_q <= 1'b1;
        if (inWin && !winInside_q && winEntered_q) winFail_q <= 1'b1;
      end
    end
  end

  // envelope band on the selected segment
  logic signed [CEL_DW-1:0] envPos, envVal;
  logic envInRange;
  assign envPos = envCfg_q[1] ? sample.y : sample.x;
  assign envVal = envCfg_q[1] ? sample.x : sample.y;
  assign envInRange = envPos >= envStart_q && envPos <= envEnd_q;

  always_ff @(posedge clk) begin
    if (reset || (sample.valid && sample.frameStart)) begin
      envFail_q <= 1'b0;
    end else if (sample.valid && envArmed_q && envCfg_q[CEL_ENV_EN] && envInRange
                 && sample.segRet == envCfg_q[CEL_ENV_SEG]) begin
      if (envVal < envDlo_q || envVal > envDhi_q) envFail_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) fail_verdict <= 1'b0;
    else if (sample.valid && sample.frameEnd)
      fail_verdict <= winFail_q || envFail_q;
  end

  // sensor test
  logic stOk;
  assign stOk = (!stEn_q[0] || absDiff(sample.x, stRefX_q) <= $signed({1'b0, stTol_q[14:0]}))
             && (!stEn_q[1] || absDiff(sample.y, stRefY_q) <= $signed({1'b0, stTol_q[14:0]}));
  logic stPend_q;

  always_ff @(posedge clk) begin
    if (reset) stPend_q <= 1'b0;
    else if (sensor_check_request || functionKey) stPend_q <= 1'b1;
    else if (sample.valid) stPend_q <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sensor_check_pass <= 1'b0;
      sensor_check_done <= 1'b0;
    end else begin
      sensor_check_done <= stPend_q && sample.valid;
      if (stPend_q && sample.valid) sensor_check_pass <= stOk;
    end
  end

  // read side
  always_ff @(posedge clk) begin
    if (reset) rdata <= 32'h0;
    else if (bus.rd) begin
      rdata <= 32'h0;
      if (bus.addr < CEL_A_SWCFG0 + 8'(CEL_NSW)) rdata <= {29'h0, swCfg_q[bus.addr[2:0]]};
      else if (bus.addr >= CEL_A_SWLIM0 && bus.addr < CEL_A_SWLIM0 + 8'(CEL_NSW))
        rdata <= {{16{swLim_q[3'(bus.addr - CEL_A_SWLIM0)][15]}},
                  swLim_q[3'(bus.addr - CEL_A_SWLIM0)]};
      else if (bus.addr == CEL_A_SWROUTE) rdata <= {16'h0, route_q};
      else if (bus.addr == CEL_A_MODE) rdata <= {31'h0, modeYtrig_q};
      else if (bus.addr == CEL_A_TOLX) rdata <= {16'h0, tolX_q};
      else if (bus.addr == CEL_A_TOLY) rdata <= {16'h0, tolY_q};
      else if (bus.addr == CEL_A_ENVCFG) rdata <= {28'h0, envCfg_q};
      else if (bus.addr == CEL_A_STTOL) rdata <= {16'h0, stTol_q};
      else if (bus.addr == CEL_A_CTRL) rdata <= {30'h0, stEn_q};
      else if (bus.addr == CEL_A_STATUS)
        rdata <= {24'h0, envArmed_q, envNotContinuous, sensor_check_pass, fail_verdict,
                  winFail_q, envFail_q, bandOn, 1'b0};
    end
  end

  chk_switch_level: assert property (@(posedge clk) disable iff (reset)
    1 |=> limit_switch_out_a == $past(swLvl[0]))
    else $error("switch a not updated from sample");
  chk_sensor_result: assert property (@(posedge clk) disable iff (reset)
    stPend_q && sample.valid |=> sensor_check_pass == $past(stOk) && sensor_check_done)
    else $error("sensor result wrong");
  chk_trig_gate: assert property (@(posedge clk) disable iff (reset)
    !modeYtrig_q && bus.wr && bus.addr < CEL_A_SWCFG0 + 8'(CEL_NSW)
    |=> !swCfg_q[$past(bus.addr[2:0])][CEL_SW_REL])
    else $error("trigger reference accepted without y-trigger mode");
  chk_gen_refuse: assert property (@(posedge clk) disable iff (reset)
    genStrobe && !genMonotonic |=> envNotContinuous && !envArmed_q)
    else $error("non-continuous generation not refused");
  chk_band_flag: assert property (@(posedge clk) disable iff (reset)
    sample.valid && !sample.frameStart && tolX_q == 16'h0 && tolY_q == 16'h0
    |=> winInside_q == $past(inWin))
    else $error("window hysteresis active with zero widths");
  chk_verdict_out: assert property (@(posedge clk) disable iff (reset)
    sample.valid && sample.frameEnd |=> fail_verdict == $past(winFail_q || envFail_q))
    else $error("verdict mismatch");
  chk_st_start: assert property (@(posedge clk) disable iff (reset)
    sensor_check_request |=> stPend_q)
    else $error("sensor request not taken");
  chk_fixed_b: assert property (@(posedge clk) disable iff (reset)
    ##1 limit_switch_out_b == $past(swAct_q[1] ^ swCfg_q[1][CEL_SW_POL]))
    else $error("switch b polarity wrong");
  chk_band_chatter: assert property (@(posedge clk) disable iff (reset)
    sample.valid && !sample.frameStart && bandOn && winInside_q && inBand && !winFail_q
    |=> !winFail_q)
    else $error("chatter inside the band gave a fail");
  chk_win_reentry: assert property (@(posedge clk) disable iff (reset)
    sample.valid && !sample.frameStart && !bandOn && inWin && !winInside_q && winEntered_q
    |=> winFail_q)
    else $error("window re-entry without band not failed");
  chk_env_excursion: assert property (@(posedge clk) disable iff (reset)
    sample.valid && !sample.frameStart && envArmed_q && envCfg_q[CEL_ENV_EN] && envInRange
    && sample.segRet == envCfg_q[CEL_ENV_SEG] && (envVal < envDlo_q || envVal > envDhi_q)
    |=> envFail_q)
    else $error("envelope excursion not flagged");
  chk_seg_gate: assert property (@(posedge clk) disable iff (reset)
    sample.valid && !sample.frameStart && sample.segRet != envCfg_q[CEL_ENV_SEG] && !envFail_q
    |=> !envFail_q)
    else $error("envelope checked on the other segment");
  // only when c owns output 0 alone; a shared output follows the later switch
  chk_route_c: assert property (@(posedge clk) disable iff (reset)
    route_q[3:0] == 4'h0 && route_q[7:4] != 4'h0 && route_q[11:8] != 4'h0
    && route_q[15:12] != 4'h0 |=> plcOut[0] == $past(swLvl[2]))
    else $error("switch c not routed to its output");
  cov_st_pass: cover property (@(posedge clk) sensor_check_done && sensor_check_pass);
  cov_fail: cover property (@(posedge clk) fail_verdict);
  cov_sw_on: cover property (@(posedge clk) swAct_q[0]);
  cov_gen_refused: cover property (@(posedge clk) genStrobe && !genMonotonic);
  cov_band_hold: cover property (@(posedge clk)
    sample.valid && bandOn && winInside_q && !inWin && inBand);

endmodule : cel_curve_eval
`default_nettype wire

//--- design/cel_pkg.sv
package cel_pkg;

  localparam int CEL_DW = 16;
  localparam int CEL_NSW = 6;
  localparam int CEL_NOUT = 8;

  // register indices on the plain port
  localparam logic [7:0] CEL_A_SWCFG0 = 8'h00;
  localparam logic [7:0] CEL_A_SWLIM0 = 8'h08;
  localparam logic [7:0] CEL_A_SWROUTE = 8'h10;
  localparam logic [7:0] CEL_A_MODE = 8'h11;
  localparam logic [7:0] CEL_A_TOLX = 8'h12;
  localparam logic [7:0] CEL_A_TOLY = 8'h13;
  localparam logic [7:0] CEL_A_ENVCFG = 8'h14;
  localparam logic [7:0] CEL_A_ENVSTART = 8'h15;
  localparam logic [7:0] CEL_A_ENVEND = 8'h16;
  localparam logic [7:0] CEL_A_ENVDLO = 8'h17;
  localparam logic [7:0] CEL_A_ENVDHI = 8'h18;
  localparam logic [7:0] CEL_A_WINLO = 8'h19;
  localparam logic [7:0] CEL_A_WINHI = 8'h1a;
  localparam logic [7:0] CEL_A_STREFX = 8'h1b;
  localparam logic [7:0] CEL_A_STREFY = 8'h1c;
  localparam logic [7:0] CEL_A_STTOL = 8'h1d;
  localparam logic [7:0] CEL_A_STATUS = 8'h1e;
  localparam logic [7:0] CEL_A_CTRL = 8'h1f;

  // switch config fields: bit0 channel (1=Y), bit1 active-low, bit2 trigger-relative
  localparam int CEL_SW_CHAN = 0;
  localparam int CEL_SW_POL = 1;
  localparam int CEL_SW_REL = 2;
  // mode register: bit0 measurement reference is Y-trigger crossing
  localparam int CEL_MODE_YTRIG = 0;
  // envelope config: [1:0] entry, bit2 return segment, bit3 enable
  localparam int CEL_ENV_SEG = 2;
  localparam int CEL_ENV_EN = 3;
  // sensor test enable bits in ctrl: bit0 X, bit1 Y
  localparam logic [15:0] CEL_ROUTE_RST = 16'he4e4;

  typedef enum logic [1:0] {
    CEL_ENTRY_LEFT = 2'h0,
    CEL_ENTRY_RIGHT = 2'h1,
    CEL_ENTRY_TOP = 2'h2,
    CEL_ENTRY_BOTTOM = 2'h3
  } cel_entry_t;

  typedef struct packed {
    logic valid;
    logic trig;
    logic segRet;
    logic frameStart;
    logic frameEnd;
    logic signed [CEL_DW-1:0] x;
    logic signed [CEL_DW-1:0] y;
  } cel_sample_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cel_bus_t;

endpackage : cel_pkg

//--- testbench/cel_plc_model.sv
`timescale 1ns/10ps
`default_nettype none
// controller side: raises the sensor test request by input bit or by function key
module cel_plc_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic startReq,
  input wire logic useKey,
  input wire logic sensor_check_done,
  input wire logic sensor_check_pass,
  output logic sensor_check_request,
  output logic functionKey,
  output logic resultSeen,
  output logic passSeen
);
  always_ff @(posedge clk) begin
    if (reset) begin
      sensor_check_request <= 1'b0;
      functionKey <= 1'b0;
    end else begin
      sensor_check_request <= startReq & ~useKey;
      functionKey <= startReq & useKey;
    end
  end

  // the result bit is only trusted in the cycle the done pulse stands
  always_ff @(posedge clk) begin
    if (reset) begin
      resultSeen <= 1'b0;
      passSeen <= 1'b0;
    end else if (sensor_check_done) begin
      resultSeen <= 1'b1;
      passSeen <= sensor_check_pass;
    end else if (startReq) begin
      resultSeen <= 1'b0;
    end
  end
endmodule : cel_plc_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cel_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  cel_sample_t sample = '0;
  cel_bus_t bus = '0;
  logic genStrobe = 1'b0;
  logic genMonotonic = 1'b0;
  logic startReq = 1'b0;
  logic useKey = 1'b0;
  logic sensor_check_request, functionKey, resultSeen, passSeen;
  logic [31:0] rdata;
  logic limit_switch_out_a, limit_switch_out_b, sensor_check_pass, sensor_check_done;
  logic fail_verdict, envNotContinuous;
  logic [CEL_NOUT-1:0] plcOut;
  int miscompares = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  cel_curve_eval DUT (.clk(clk), .reset(reset), .sample(sample), .bus(bus),
    .sensor_check_request(sensor_check_request), .functionKey(functionKey),
    .genStrobe(genStrobe), .genMonotonic(genMonotonic), .rdata(rdata),
    .limit_switch_out_a(limit_switch_out_a), .limit_switch_out_b(limit_switch_out_b),
    .plcOut(plcOut), .sensor_check_pass(sensor_check_pass),
    .sensor_check_done(sensor_check_done), .fail_verdict(fail_verdict),
    .envNotContinuous(envNotContinuous));

  cel_plc_model plc (.clk(clk), .reset(reset), .startReq(startReq), .useKey(useKey),
    .sensor_check_done(sensor_check_done), .sensor_check_pass(sensor_check_pass),
    .sensor_check_request(sensor_check_request), .functionKey(functionKey),
    .resultSeen(resultSeen), .passSeen(passSeen));

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk("rdata", rdata, exp);
  endtask : rd

  // one valid sample; f is {trig, segRet, frameStart, frameEnd}
  task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y,
                     input logic [3:0] f);
    @(posedge clk);
    sample <= {1'b1, f, x, y};
    @(posedge clk);
    sample <= '0;
  endtask : smp

  task automatic smpw(input logic signed [15:0] x, input logic signed [15:0] y,
                      input logic [3:0] f);
    smp(x, y, f);
    repeat (3) @(posedge clk);
    #1;
  endtask : smpw

  task automatic gen(input logic mono);
    @(posedge clk);
    genStrobe <= 1'b1;
    genMonotonic <= mono;
    @(posedge clk);
    genStrobe <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("envNotContinuous", 32'(envNotContinuous), 32'(!mono));
  endtask : gen

  task automatic frame(input string nm, input logic signed [15:0] xs [5],
                       input logic signed [15:0] ys [5], input logic [4:0] ret, input logic e);
    for (int i = 0; i < 5; i++) begin
      smp(xs[i], ys[i], {1'b0, ret[i], i == 0, i == 4});
    end
    repeat (3) @(posedge clk);
    #1 chk(nm, 32'(fail_verdict), 32'(e));
  endtask : frame

  task automatic stest(input logic k, input logic signed [15:0] x, input logic e);
    int i;
    @(posedge clk);
    useKey <= k;
    startReq <= 1'b1;
    @(posedge clk);
    startReq <= 1'b0;
    repeat (2) @(posedge clk);
    smp(x, 16'sh0, 4'h0);
    i = 0;
    while (resultSeen !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    if (i >= 20) begin
      $display("Error sensor_check_done expected 1 seen 0");
      miscompares++;
      final_report();
    end
    #1 chk("sensor_pass", 32'(passSeen), 32'(e));
  endtask : stest

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(CEL_A_SWLIM0, 32'h00007fff);
    rd(CEL_A_SWROUTE, 32'h0000e4e4);
    wr(8'h20, 32'h00001234);
    rd(8'h20, 32'h0);
    chk("plcOut_reset", 32'(plcOut), 32'h0);
    $display("test registers done");

    wr(CEL_A_SWLIM0, 32'h00000064);
    wr(CEL_A_SWCFG0, 32'h0);
    wr(CEL_A_SWLIM0 + 8'h01, 32'h00000032);
    wr(CEL_A_SWCFG0 + 8'h01, 32'h00000003);
    smpw(16'sh0065, 16'sh0, 4'h0);
    chk("out_a", 32'(limit_switch_out_a), 32'h1);
    chk("out_b", 32'(limit_switch_out_b), 32'h1);
    smpw(16'sh0064, 16'sh0033, 4'h0);
    chk("out_a", 32'(limit_switch_out_a), 32'h0);
    chk("out_b", 32'(limit_switch_out_b), 32'h0);
    $display("test limits done");

    // switch c only, the other routed switches keep the unreachable reset limit
    wr(CEL_A_SWLIM0 + 8'h02, 32'h0000000a);
    wr(CEL_A_SWROUTE, 32'h00003210);
    smpw(16'sh000b, 16'sh0, 4'h0);
    chk("plcOut", 32'(plcOut), 32'h00000001);
    wr(CEL_A_SWROUTE, 32'h00003215);
    smpw(16'sh000b, 16'sh0, 4'h0);
    chk("plcOut", 32'(plcOut), 32'h00000020);
    $display("test routing done");

    wr(CEL_A_SWCFG0, 32'h00000004);
    rd(CEL_A_SWCFG0, 32'h0);
    wr(CEL_A_MODE, 32'h00000001);
    wr(CEL_A_SWCFG0, 32'h00000004);
    rd(CEL_A_SWCFG0, 32'h00000004);
    smpw(16'sh00c8, 16'sh0, 4'h8);
    smpw(16'sh00fa, 16'sh0, 4'h0);
    chk("out_a_rel", 32'(limit_switch_out_a), 32'h0);
    smpw(16'sh012d, 16'sh0, 4'h0);
    chk("out_a_rel", 32'(limit_switch_out_a), 32'h1);
    wr(CEL_A_SWCFG0, 32'h0);
    wr(CEL_A_MODE, 32'h0);
    $display("test trigger reference done");

    wr(CEL_A_WINLO, 32'h00000064);
    wr(CEL_A_WINHI, 32'h000000c8);
    wr(CEL_A_TOLX, 32'h0);
    frame("win_once", '{50, 120, 150, 180, 250}, '{50, 50, 50, 50, 50}, 5'h0, 1'b0);
    frame("win_chatter", '{50, 195, 205, 195, 250}, '{50, 50, 50, 50, 50}, 5'h0, 1'b1);
    wr(CEL_A_TOLX, 32'h0000000a);
    frame("win_band", '{50, 195, 205, 195, 250}, '{50, 50, 50, 50, 50}, 5'h0, 1'b0);
    wr(CEL_A_TOLX, 32'h0);
    $display("test tolerance band done");

    for (int e = 0; e < 4; e++) begin
      wr(CEL_A_ENVCFG, 32'(e) | 32'h8);
      rd(CEL_A_ENVCFG, 32'(e) | 32'h8);
    end
    // left entry, forward segment, and an accepted generation arm the band check
    wr(CEL_A_ENVCFG, 32'h00000008);
    gen(1'b1);
    rd(CEL_A_STATUS, 32'h00000080);
    wr(CEL_A_ENVSTART, 32'h0);
    wr(CEL_A_ENVEND, 32'h000003e8);
    wr(CEL_A_ENVDLO, 32'h0);
    wr(CEL_A_ENVDHI, 32'h00000064);
    frame("env_in", '{50, 120, 150, 180, 250}, '{50, 50, 50, 50, 50}, 5'h0, 1'b0);
    frame("env_out", '{50, 120, 150, 180, 250}, '{50, 50, 500, 50, 50}, 5'h0, 1'b1);
    frame("env_ret", '{50, 120, 150, 180, 250}, '{50, 50, 50, 500, 500}, 5'h18, 1'b0);
    gen(1'b0);
    rd(CEL_A_STATUS, 32'h00000040);
    $display("test envelope done");

    wr(CEL_A_CTRL, 32'h00000001);
    wr(CEL_A_STREFX, 32'h000003e8);
    wr(CEL_A_STTOL, 32'h0000000a);
    stest(1'b0, 16'sh03ed, 1'b1);
    stest(1'b1, 16'sh03fc, 1'b0);
    $display("test sensor check done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
